//--- design/dect_counter_timer.sv
// Top of the dual event counter timer with its register port
//
// Contract
// - Two independent units 0 and 1 exist and the unit choice picks which one settings and readouts address.
// - A unit adds one to its count each time its chosen increment source fires.
// - Increment sources are off, microsecond tick, pins, software outputs, unit start and end, combiner outputs, exposure start and end, frame arm wait.
// - A qualifiable increment source is taken as low level, high level, falling, rising or any edge.
// - A unit pulses its start event when its count reaches the start delay count.
// - A unit pulses its end event when its count reaches the end length count.
// - Arm and clear sources never both stand, choosing one non-off turns the other off.
// - A unit with an arm source starts counting when that source fires, chosen from the increment set.
// - A qualifiable arm source is taken as low level, high level, falling, rising or any edge.
// - A unit with a clear source ends its count when that source fires, chosen from the increment set; the code restarts the count from zero.
// - A qualifiable clear source is taken as low level, high level, falling, rising or any edge.
// - The live count of the chosen unit can be read at any time.
// - A clear copies the count of that moment into the captured count of the unit.
// - The state of the chosen unit can be read.
// - States are idle, waiting for arm, active, completed and overflow.
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module dect_counter_timer (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Register port
    input wire dect_pkg::dect_req_t regReq,
    output logic [dect_pkg::DATA_W-1:0] regRdata,
    // Outside sources
    input wire dect_pkg::dect_src_in_t srcIn,
    // Unit events
    output logic [dect_pkg::UNIT_N-1:0] delayDonePulse,
    output logic [dect_pkg::UNIT_N-1:0] lengthDonePulse,
    // Microsecond tick
    output logic microsecondPulse
);
    import dect_pkg::*;

    // ************************************************
    // Declarations
    // ************************************************

    logic [TICK_W-1:0] tickCnt_q;
    logic tick_q;
    logic unitChoice_q;
    dect_cfg_t cfg_q [UNIT_N];
    logic [SRC_N-1:0] srcVec;
    logic [CNT_W-1:0] count_q [UNIT_N];
    logic [CNT_W-1:0] capt_q [UNIT_N];
    dect_state_t state_q [UNIT_N];
    logic [UNIT_N-1:0] delayDone_q;
    logic [UNIT_N-1:0] lengthDone_q;
    logic [UNIT_N-1:0] incFire;
    logic [UNIT_N-1:0] armFire;
    logic [UNIT_N-1:0] clrFire;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdMux;
    logic wrEn;
    dect_cfg_t selCfg;

    // ************************************************
    // Microsecond tick
    // ************************************************

    // Divider gives one pulse every TICK_CYCLES clocks
    always_ff @(posedge mclk) begin
        if (rst) begin
            tickCnt_q <= '0;
            tick_q <= 1'b0;
        end else if (tickCnt_q == TICK_W'(TICK_CYCLES - 1)) begin
            tickCnt_q <= '0;
            tick_q <= 1'b1;
        end else begin
            tickCnt_q <= tickCnt_q + 1'b1;
            tick_q <= 1'b0;
        end
    end

    // Tick leaves straight from its flip-flop
    assign microsecondPulse = tick_q;

    // ************************************************
    // Source vector
    // ************************************************

    // Gather every source at its code position
    always_comb begin
        srcVec = '0;
        srcVec[SRC_TICK] = tick_q;
        srcVec[SRC_PIN0 +: 4] = srcIn.ioPin;
        srcVec[SRC_SWOUT0 +: 4] = srcIn.softwareOut;
        srcVec[SRC_U0_START] = delayDone_q[0];
        srcVec[SRC_U1_START] = delayDone_q[1];
        srcVec[SRC_U0_END] = lengthDone_q[0];
        srcVec[SRC_U1_END] = lengthDone_q[1];
        srcVec[SRC_COMB0 +: 2] = srcIn.combinerOut;
        srcVec[SRC_EXP_START] = srcIn.exposureStart;
        srcVec[SRC_EXP_END] = srcIn.exposureEnd;
        srcVec[SRC_FRAME_WAIT] = srcIn.frameArmWait;
    end

    // ************************************************
    // Settings registers
    // ************************************************

    // One write strobe serves every setting
    assign wrEn = regReq.wr;

    // Unit choice steers every per-unit access
    always_ff @(posedge mclk) begin
        if (rst) begin
            unitChoice_q <= 1'b0;
        end else if (wrEn && regReq.addr == REG_UNIT_CHOICE) begin
            unitChoice_q <= regReq.wdata[0];
        end
    end

    // Per unit settings, written only for the chosen unit
    generate
        for (genvar u = 0; u < UNIT_N; u++) begin : gCfg
            logic hit;
            assign hit = wrEn && (unitChoice_q == u[0]);
            always_ff @(posedge mclk) begin
                if (rst) begin
                    cfg_q[u].incSel <= RST_SRC;
                    cfg_q[u].incQual <= RST_QUAL;
                    cfg_q[u].armSel <= RST_SRC;
                    cfg_q[u].armQual <= RST_QUAL;
                    cfg_q[u].clrSel <= RST_SRC;
                    cfg_q[u].clrQual <= RST_QUAL;
                    cfg_q[u].startDelay <= RST_COUNT;
                    cfg_q[u].endLength <= RST_COUNT;
                end else if (hit) begin
                    case (regReq.addr)
                        REG_INC_SRC: begin
                            cfg_q[u].incSel <= legalSrc(regReq.wdata);
                        end
                        REG_INC_QUAL: begin
                            cfg_q[u].incQual <= regReq.wdata[QUAL_W-1:0];
                        end
                        REG_START_DELAY: begin
                            cfg_q[u].startDelay <= regReq.wdata;
                        end
                        REG_END_LENGTH: begin
                            cfg_q[u].endLength <= regReq.wdata;
                        end
                        REG_ARM_SRC: begin
                            cfg_q[u].armSel <= legalSrc(regReq.wdata);
                            if (legalSrc(regReq.wdata) != SRC_OFF) begin
                                cfg_q[u].clrSel <= SRC_OFF;
                            end
                        end
                        REG_ARM_QUAL: begin
                            cfg_q[u].armQual <= regReq.wdata[QUAL_W-1:0];
                        end
                        REG_CLR_SRC: begin
                            cfg_q[u].clrSel <= legalSrc(regReq.wdata);
                            if (legalSrc(regReq.wdata) != SRC_OFF) begin
                                cfg_q[u].armSel <= SRC_OFF;
                            end
                        end
                        REG_CLR_QUAL: begin
                            cfg_q[u].clrQual <= regReq.wdata[QUAL_W-1:0];
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end
    endgenerate

    // ************************************************
    // Counter units
    // ************************************************

    // One unit: pickers, state machine, capture
    generate
        for (genvar u = 0; u < UNIT_N; u++) begin : gUnit
            logic armMode;
            logic clrMode;
            logic [CNT_W-1:0] nextCount;

            // Mode flags and the next count
            assign armMode = (cfg_q[u].armSel != SRC_OFF);
            assign clrMode = (cfg_q[u].clrSel != SRC_OFF);
            assign nextCount = count_q[u] + 1'b1;

            // Increment source
            dect_event_pick uIncPick (
                .mclk(mclk),
                .rst(rst),
                .sel(cfg_q[u].incSel),
                .qual(cfg_q[u].incQual),
                .srcVec(srcVec),
                .fire(incFire[u])
            );

            // Arm source
            dect_event_pick uArmPick (
                .mclk(mclk),
                .rst(rst),
                .sel(cfg_q[u].armSel),
                .qual(cfg_q[u].armQual),
                .srcVec(srcVec),
                .fire(armFire[u])
            );

            // Clear source
            dect_event_pick uClrPick (
                .mclk(mclk),
                .rst(rst),
                .sel(cfg_q[u].clrSel),
                .qual(cfg_q[u].clrQual),
                .srcVec(srcVec),
                .fire(clrFire[u])
            );

            // State, count and event pulses of one unit
            always_ff @(posedge mclk) begin
                if (rst) begin
                    state_q[u] <= ST_IDLE;
                    count_q[u] <= RST_COUNT;
                    delayDone_q[u] <= 1'b0;
                    lengthDone_q[u] <= 1'b0;
                end else begin
                    delayDone_q[u] <= 1'b0;
                    lengthDone_q[u] <= 1'b0;
                    if (cfg_q[u].incSel == SRC_OFF) begin
                        state_q[u] <= ST_IDLE;
                        count_q[u] <= RST_COUNT;
                    end else if (clrMode && clrFire[u]) begin
                        // Clear outranks increments
                        state_q[u] <= ST_ACTIVE;
                        count_q[u] <= RST_COUNT;
                    end else begin
                        case (state_q[u])
                            ST_IDLE: begin
                                count_q[u] <= RST_COUNT;
                                state_q[u] <= armMode ? ST_WAIT_ARM : ST_ACTIVE;
                            end
                            ST_WAIT_ARM: begin
                                if (armFire[u]) begin
                                    state_q[u] <= ST_ACTIVE;
                                    count_q[u] <= RST_COUNT;
                                end
                            end
                            ST_ACTIVE: begin
                                // Zero never matches
                                if (incFire[u]) begin
                                    if (count_q[u] == '1) begin
                                        // Full count: overflow
                                        state_q[u] <= ST_OVERFLOW;
                                    end else begin
                                        count_q[u] <= nextCount;
                                        if (nextCount == cfg_q[u].startDelay) begin
                                            delayDone_q[u] <= 1'b1;
                                        end
                                        if (nextCount == cfg_q[u].endLength) begin
                                            lengthDone_q[u] <= 1'b1;
                                            state_q[u] <= ST_DONE;
                                        end
                                    end
                                end
                            end
                            ST_DONE, ST_OVERFLOW: begin
                                if (armMode && armFire[u]) begin
                                    state_q[u] <= ST_ACTIVE;
                                    count_q[u] <= RST_COUNT;
                                end
                            end
                            default: begin
                                state_q[u] <= ST_IDLE;
                            end
                        endcase
                    end
                end
            end

            // Captured count: a clear wins over a software write
            always_ff @(posedge mclk) begin
                if (rst) begin
                    capt_q[u] <= RST_COUNT;
                end else if (cfg_q[u].incSel != SRC_OFF && clrMode && clrFire[u]) begin
                    capt_q[u] <= count_q[u];
                end else if (wrEn && regReq.addr == REG_CAPTURED
                        && unitChoice_q == u[0]) begin
                    capt_q[u] <= regReq.wdata;
                end
            end
        end
    endgenerate

    // Pulses straight from flip-flops
    assign delayDonePulse = delayDone_q;
    assign lengthDonePulse = lengthDone_q;

    // ************************************************
    // Read back
    // ************************************************

    // Settings of the chosen unit
    assign selCfg = cfg_q[unitChoice_q];

    // Register mux for the chosen unit; unmapped reads give zero
    always_comb begin
        rdMux = '0;
        case (regReq.addr)
            REG_UNIT_CHOICE: rdMux[0] = unitChoice_q;
            REG_INC_SRC: rdMux[SRC_W-1:0] = selCfg.incSel;
            REG_INC_QUAL: rdMux[QUAL_W-1:0] = selCfg.incQual;
            REG_START_DELAY: rdMux = selCfg.startDelay;
            REG_END_LENGTH: rdMux = selCfg.endLength;
            REG_ARM_SRC: rdMux[SRC_W-1:0] = selCfg.armSel;
            REG_ARM_QUAL: rdMux[QUAL_W-1:0] = selCfg.armQual;
            REG_CLR_SRC: rdMux[SRC_W-1:0] = selCfg.clrSel;
            REG_CLR_QUAL: rdMux[QUAL_W-1:0] = selCfg.clrQual;
            REG_LIVE_COUNT: rdMux = count_q[unitChoice_q];
            REG_CAPTURED: rdMux = capt_q[unitChoice_q];
            REG_UNIT_STATE: rdMux[2:0] = state_q[unitChoice_q];
            default: rdMux = '0;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_q <= '0;
        end else if (regReq.rd) begin
            rdata_q <= rdMux;
        end else begin
            rdata_q <= '0;
        end
    end

    // Read data straight from its flip-flop
    assign regRdata = rdata_q;

endmodule
`default_nettype wire

//--- design/dect_pkg.sv
// Shared constants, types and decode functions of the dual event counter timer
package dect_pkg;

    // ********************************
    // Widths
    // ********************************
    localparam int CNT_W = 32;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int SRC_W = 5;
    localparam int SRC_N = 19;
    localparam int QUAL_W = 3;
    localparam int UNIT_N = 2;

    // ********************************
    // Register offsets (byte addresses)
    // ********************************
    localparam logic [7:0] REG_UNIT_CHOICE = 8'h00;
    localparam logic [7:0] REG_INC_SRC = 8'h04;
    localparam logic [7:0] REG_INC_QUAL = 8'h08;
    localparam logic [7:0] REG_START_DELAY = 8'h0C;
    localparam logic [7:0] REG_END_LENGTH = 8'h10;
    localparam logic [7:0] REG_ARM_SRC = 8'h14;
    localparam logic [7:0] REG_ARM_QUAL = 8'h18;
    localparam logic [7:0] REG_CLR_SRC = 8'h1C;
    localparam logic [7:0] REG_CLR_QUAL = 8'h20;
    localparam logic [7:0] REG_LIVE_COUNT = 8'h24;
    localparam logic [7:0] REG_CAPTURED = 8'h28;
    localparam logic [7:0] REG_UNIT_STATE = 8'h2C;

    // ********************************
    // Source codes, also bit indices of the source vector
    // ********************************
    localparam logic [4:0] SRC_OFF = 5'h00;
    localparam logic [4:0] SRC_TICK = 5'h01;
    localparam logic [4:0] SRC_PIN0 = 5'h02;
    localparam logic [4:0] SRC_SWOUT0 = 5'h06;
    localparam logic [4:0] SRC_U0_START = 5'h0A;
    localparam logic [4:0] SRC_U1_START = 5'h0B;
    localparam logic [4:0] SRC_U0_END = 5'h0C;
    localparam logic [4:0] SRC_U1_END = 5'h0D;
    localparam logic [4:0] SRC_COMB0 = 5'h0E;
    localparam logic [4:0] SRC_EXP_START = 5'h10;
    localparam logic [4:0] SRC_EXP_END = 5'h11;
    localparam logic [4:0] SRC_FRAME_WAIT = 5'h12;

    // ********************************
    // Qualification codes
    // ********************************
    localparam logic [2:0] QUAL_LEVEL_LOW = 3'h0;
    localparam logic [2:0] QUAL_LEVEL_HIGH = 3'h1;
    localparam logic [2:0] QUAL_FALL = 3'h2;
    localparam logic [2:0] QUAL_RISE = 3'h3;
    localparam logic [2:0] QUAL_ANY = 3'h4;

    // ********************************
    // Reset values and timing
    // ********************************
    localparam logic [4:0] RST_SRC = 5'h00;
    localparam logic [2:0] RST_QUAL = 3'h3;
    localparam logic [31:0] RST_COUNT = 32'h0000_0000;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int TICK_PERIOD_PS = 1000000;
    localparam int TICK_CYCLES = TICK_PERIOD_PS / CLK_PERIOD_PS;
    localparam int TICK_W = 8;

    // Unit state, read back in this order
    typedef enum logic [2:0] {
        ST_IDLE, ST_WAIT_ARM, ST_ACTIVE, ST_DONE, ST_OVERFLOW
    } dect_state_t;

    // Register bus request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } dect_req_t;

    // Outside signals that can drive a unit
    typedef struct packed {
        logic [3:0] ioPin;
        logic [3:0] softwareOut;
        logic [1:0] combinerOut;
        logic exposureStart;
        logic exposureEnd;
        logic frameArmWait;
    } dect_src_in_t;

    // Per unit settings
    typedef struct packed {
        logic [SRC_W-1:0] incSel;
        logic [QUAL_W-1:0] incQual;
        logic [SRC_W-1:0] armSel;
        logic [QUAL_W-1:0] armQual;
        logic [SRC_W-1:0] clrSel;
        logic [QUAL_W-1:0] clrQual;
        logic [CNT_W-1:0] startDelay;
        logic [CNT_W-1:0] endLength;
    } dect_cfg_t;

    // Sources that are single-cycle events and take no qualification
    function automatic logic isPulseSrc(input logic [SRC_W-1:0] s);
        isPulseSrc = (s == SRC_TICK) || (s == SRC_EXP_START) || (s == SRC_EXP_END)
            || ((s >= SRC_U0_START) && (s <= SRC_U1_END));
    endfunction

    // Legal source code
    function automatic logic [SRC_W-1:0] legalSrc(input logic [DATA_W-1:0] v);
        legalSrc = (v < SRC_N) ? v[SRC_W-1:0] : SRC_OFF;
    endfunction

endpackage

//--- design/dect_event_pick.sv
// Source picker and qualifier used for increment, arm and clear of a unit
`timescale 1ns/100ps
`default_nettype none
module dect_event_pick (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Selection
    input wire logic [dect_pkg::SRC_W-1:0] sel,
    input wire logic [dect_pkg::QUAL_W-1:0] qual,
    // All sources
    input wire logic [dect_pkg::SRC_N-1:0] srcVec,
    // Qualified event
    output logic fire
);
    import dect_pkg::*;

    logic level;
    logic prev_q;
    logic [SRC_W-1:0] selSeen_q;
    logic edgeOk;

    // Level of the chosen signal
    assign level = (sel < SRC_N) ? srcVec[sel] : 1'b0;
    // Edges are trusted only once the same source was seen last cycle
    assign edgeOk = (selSeen_q == sel);

    // History for edge detection
    always_ff @(posedge mclk) begin
        if (rst) begin
            prev_q <= 1'b0;
            selSeen_q <= SRC_OFF;
        end else begin
            prev_q <= level;
            selSeen_q <= sel;
        end
    end

    // Qualification
    always_comb begin
        fire = 1'b0;
        if (sel == SRC_OFF) begin
            fire = 1'b0;
        end else if (isPulseSrc(sel)) begin
            fire = level;
        end else begin
            case (qual)
                QUAL_LEVEL_LOW: fire = !level;
                QUAL_LEVEL_HIGH: fire = level;
                QUAL_FALL: fire = edgeOk && prev_q && !level;
                QUAL_RISE: fire = edgeOk && !prev_q && level;
                QUAL_ANY: fire = edgeOk && (prev_q ^ level);
                default: fire = 1'b0;
            endcase
        end
    end

endmodule
`default_nettype wire

//--- testbench/dect_sva.sv
// Port checker of the dual event counter timer
`timescale 1ns/100ps
`default_nettype none
module dect_sva (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Register port
    input wire dect_pkg::dect_req_t regReq,
    input wire logic [dect_pkg::DATA_W-1:0] regRdata,
    // Unit events and tick
    input wire logic [dect_pkg::UNIT_N-1:0] delayDonePulse,
    input wire logic [dect_pkg::UNIT_N-1:0] lengthDonePulse,
    input wire logic microsecondPulse
);
    import dect_pkg::*;
    // ********************************
    // Properties of the outputs
    // ********************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    a_read_window: assert property (
        regRdata != 32'h0 |-> $past(regReq.rd))
        else $error("read data outside its cycle");
    a_unmapped_zero: assert property (
        regReq.rd && regReq.addr > REG_UNIT_STATE |=> regRdata == 32'h0)
        else $error("unmapped read not zero");
    a_state_range: assert property (
        regReq.rd && regReq.addr == REG_UNIT_STATE |=> regRdata <= 32'h4)
        else $error("state code out of range");
    a_reset_quiet: assert property (
        $fell(rst) |-> regRdata == 32'h0 && delayDonePulse == 2'h0
            && lengthDonePulse == 2'h0 && !microsecondPulse)
        else $error("output active after reset");
    a_tick_single: assert property (
        microsecondPulse |=> !microsecondPulse)
        else $error("tick longer than a cycle");
    a_tick_period: assert property (
        microsecondPulse |-> ##200 microsecondPulse)
        else $error("tick period wrong");
    a_start_single: assert property (
        delayDonePulse[0] |=> !delayDonePulse[0])
        else $error("start event too long");
    a_end_single: assert property (
        $rose(lengthDonePulse[0]) |=> $fell(lengthDonePulse[0]))
        else $error("end event too long");
endmodule
bind dect_counter_timer dect_sva i_sva (.mclk(mclk), .rst(rst), .regReq(regReq),
    .regRdata(regRdata), .delayDonePulse(delayDonePulse),
    .lengthDonePulse(lengthDonePulse), .microsecondPulse(microsecondPulse));
`default_nettype wire

//--- testbench/dect_src_model.sv
// Model of the pins, software outputs and exposure signals feeding the block
`timescale 1ns/100ps
`default_nettype none
module dect_src_model (
    // Clock
    input wire logic mclk,
    // Sources towards the block
    output var dect_pkg::dect_src_in_t srcIn
);
    logic [3:0] pinIdle = 4'h0;
    logic [3:0] pinAct = 4'h0;
    logic [3:0] swLevel = 4'h0;
    logic [1:0] expReq = 2'h0;
    initial srcIn = '0;
    // Drive all sources just after the edge
    always @(posedge mclk) begin
        srcIn.ioPin <= pinIdle ^ pinAct;
        srcIn.softwareOut <= swLevel;
        srcIn.combinerOut <= swLevel[1:0];
        srcIn.exposureStart <= expReq[0];
        srcIn.exposureEnd <= expReq[1];
        srcIn.frameArmWait <= swLevel[3];
    end
    // Move a pin away from idle n times, two cycles each way
    task automatic pulses(input int p, input int n);
        repeat (n) begin
            @(posedge mclk);
            pinAct[p] <= 1'b1;
            repeat (2) @(posedge mclk);
            pinAct[p] <= 1'b0;
            @(posedge mclk);
        end
    endtask
    // Hold a pin away from idle for m cycles
    task automatic level(input int p, input int m);
        @(posedge mclk);
        pinAct[p] <= 1'b1;
        repeat (m) @(posedge mclk);
        pinAct[p] <= 1'b0;
    endtask
    // One-cycle exposure event, 0 start, 1 end
    task automatic expPulse(input int i);
        @(posedge mclk);
        expReq[i] <= 1'b1;
        @(posedge mclk);
        expReq[i] <= 1'b0;
    endtask
endmodule
`default_nettype wire

//--- testbench/dect_counter_timer_tb.sv
// Self-checking bench of the dual event counter timer
`timescale 1ns/100ps
`default_nettype none
module dect_counter_timer_tb;
    import dect_pkg::*;
    logic mclk;
    logic rst;
    dect_req_t regReq;
    logic [DATA_W-1:0] regRdata;
    dect_src_in_t srcIn;
    logic [UNIT_N-1:0] delayDonePulse;
    logic [UNIT_N-1:0] lengthDonePulse;
    logic microsecondPulse;
    logic [DATA_W-1:0] expQ[$];
    logic rdSeen = 1'b0;
    logic [7:0] rnd = 8'h44;
    int err_total = 0;
    int checked = 0;
    int startCnt = 0;
    int endCnt = 0;
    int cycles = 0;
    dect_counter_timer i_dut (.mclk(mclk), .rst(rst), .regReq(regReq), .regRdata(regRdata),
        .srcIn(srcIn), .delayDonePulse(delayDonePulse), .lengthDonePulse(lengthDonePulse),
        .microsecondPulse(microsecondPulse));
    dect_src_model i_src (.mclk(mclk), .srcIn(srcIn));
    // ********************************
    // Helpers
    // ********************************
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Register write, one strobe cycle
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        regReq.addr <= a;
        regReq.wdata <= d;
        regReq.wr <= 1'b1;
        @(posedge mclk);
        regReq.wr <= 1'b0;
    endtask
    // Register read, the expected word is noted for the monitor
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk);
        regReq.addr <= a;
        regReq.rd <= 1'b1;
        expQ.push_back(e);
        @(posedge mclk);
        regReq.rd <= 1'b0;
    endtask
    // Clock
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // Monitor: read data, unit events and the run limit
    always @(posedge mclk) begin
        if (rdSeen === 1'b1) begin
            chk(regRdata, expQ.pop_front());
        end
        rdSeen <= regReq.rd;
        startCnt += $countones(delayDonePulse);
        endCnt += $countones(lengthDonePulse);
        cycles++;
        if (cycles > 5000) begin
            err_total++;
            end_sim();
        end
    end
    // ********************************
    // Scenarios
    // ********************************
    initial begin
        int k;
        int n;
        int m;
        rst = 1'b1;
        regReq = '0;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        rd(REG_INC_QUAL, 32'h3);
        rd(REG_UNIT_STATE, 32'h0);
        rd(8'h30, 32'h0);
        wr(REG_ARM_SRC, 32'h2);
        wr(REG_CLR_SRC, 32'h3);
        rd(REG_ARM_SRC, 32'h0);
        rd(REG_CLR_SRC, 32'h3);
        wr(REG_CLR_SRC, 32'h0);
        wr(REG_START_DELAY, 32'h2);
        // Every qualifier on pin 0, count stops at the end length
        for (int q = 0; q < 5; q++) begin
            rnd = lfsr(rnd);
            i_src.swLevel <= rnd[7:4];
            k = 3 + int'(rnd[1:0]);
            n = (q == 2 || q == 3) ? k : 2 * k;
            i_src.pinIdle[0] <= (q == 0);
            wr(REG_INC_QUAL, 32'(q));
            wr(REG_END_LENGTH, 32'(n));
            wr(REG_INC_SRC, 32'(SRC_PIN0));
            repeat (4) @(posedge mclk);
            i_src.pulses(0, k);
            repeat (4) @(posedge mclk);
            rd(REG_LIVE_COUNT, 32'(n));
            rd(REG_UNIT_STATE, 32'h3);
            chk(32'(startCnt), 32'(q + 1));
            chk(32'(endCnt), 32'(q + 1));
            if (q < 4) begin
                wr(REG_INC_SRC, 32'h0);
            end
        end
        // Arm on exposure start restarts a finished unit
        wr(REG_ARM_SRC, 32'(SRC_EXP_START));
        i_src.expPulse(0);
        repeat (2) @(posedge mclk);
        rd(REG_UNIT_STATE, 32'h2);
        rd(REG_LIVE_COUNT, 32'h0);
        // Unit 1 counts a high level and is cleared by exposure end
        wr(REG_UNIT_CHOICE, 32'h1);
        rd(REG_UNIT_STATE, 32'h0);
        rnd = lfsr(rnd);
        m = 4 + int'(rnd[2:0]);
        wr(REG_INC_QUAL, 32'h1);
        wr(REG_START_DELAY, 32'h2);
        wr(REG_END_LENGTH, 32'(m));
        wr(REG_CLR_SRC, 32'(SRC_EXP_END));
        wr(REG_INC_SRC, 32'(SRC_PIN0) + 32'h1);
        repeat (3) @(posedge mclk);
        i_src.level(1, m);
        i_src.expPulse(1);
        repeat (2) @(posedge mclk);
        rd(REG_CAPTURED, 32'(m));
        rd(REG_LIVE_COUNT, 32'h0);
        rd(REG_UNIT_STATE, 32'h2);
        chk(32'(startCnt), 32'h6);
        chk(32'(endCnt), 32'h6);
        wr(REG_ARM_SRC, 32'h4);
        wr(REG_INC_SRC, 32'h0);
        wr(REG_INC_SRC, 32'h3);
        rd(REG_CLR_SRC, 32'h0);
        rd(REG_UNIT_STATE, 32'h1);
        i_src.pulses(2, 1);
        rd(REG_UNIT_STATE, 32'h2);
        wr(REG_UNIT_CHOICE, 32'h0);
        rd(REG_UNIT_STATE, 32'h2);
        repeat (250) @(posedge mclk);
        end_sim();
    end
endmodule
`default_nettype wire
